// File: design/cpa_codec_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "cpa_regs.svh"

module cpa_codec_ctrl (
	input  wire logic                    clock_i,
	input  wire logic                    resetn_i,
	input  wire logic                    ce_i,
	input  wire logic                    fs_tick_i,
	input  wire logic                    wr_valid_i,
	input  wire cpa_pkg::cpa_ctrl_word_t wr_word_i,
	output var  logic                    adc_power_down_o,
	output var  logic [7:0]              adc_fade_level_o,
	output var  logic                    dac_power_down_o,
	output var  logic [7:0]              dac_fade_level_o,
	output var  logic                    dac_single_ended_o,
	output var  logic                    dac_clock_set_select_o,
	output var  logic [2:0]              dac_if_mode_o,
	output var  logic [1:0]              dac_data_format_o,
	output var  logic [7:0]              dac_atten_left_o,
	output var  logic [7:0]              dac_atten_right_o,
	output var  logic                    dac_mute_left_o,
	output var  logic                    dac_mute_right_o,
	output var  logic                    dac_ramp_busy_o
);
	import cpa_pkg::*;

	cpa_state_t st_q;
	cpa_state_t st_d;
	logic       wr_pwr;
	logic       wr_att_l;
	logic       wr_att_r;
	logic       wr_clk;

	// ****************************************
	// Power-save sequencer
	// ****************************************
	function automatic cpa_pwr_t pwr_step(cpa_pwr_t p, logic ps, logic tick);
		cpa_pwr_t n;
		n = p;
		case (p.state)
			CPA_PS_DOWN: begin
				n.fade = 11'h000;
				if (!ps) begin
					n.state = CPA_PS_FADE_IN;
				end
			end
			CPA_PS_FADE_IN: begin
				if (ps) begin
					n.state = CPA_PS_FADE_OUT;
				end else if (tick) begin
					if (p.fade == `CPA_FADE_LAST) begin
						n.state = CPA_PS_RUN;
					end else begin
						n.fade = p.fade + 11'h001;
					end
				end
			end
			CPA_PS_RUN: begin
				if (ps) begin
					n.state = CPA_PS_FADE_OUT;
				end
			end
			CPA_PS_FADE_OUT: begin
				if (!ps) begin
					n.state = CPA_PS_FADE_IN;
				end else if (tick) begin
					if (p.fade == 11'h000) begin
						n.state = CPA_PS_DOWN;
					end else begin
						n.fade = p.fade - 11'h001;
					end
				end
			end
			default: begin
				n.state = CPA_PS_DOWN;
				n.fade  = 11'h000;
			end
		endcase
		n.down = (n.state == CPA_PS_DOWN);
		return n;
	endfunction

	// ****************************************
	// Attenuation ramp with command buffer
	// ****************************************
	function automatic cpa_att_t att_step(cpa_att_t a, logic wr, logic [7:0] code, logic tick);
		cpa_att_t   n;
		logic [7:0] tgt;
		n   = a;
		tgt = (code < `CPA_ATT_MIN) ? `CPA_ATT_MUTE : code;
		if (wr) begin
			n.code = code;
		end
		if (a.level != a.target) begin
			if (tick) begin
				n.cnt = a.cnt + 3'h1;
				if (a.cnt == `CPA_ATT_STEP_LAST) begin
					n.level = (a.level < a.target) ? a.level + 8'h01 : a.level - 8'h01;
				end
			end
			if (wr) begin
				n.buf_code = tgt;
				n.pending  = 1'b1;
			end
		end else if (wr) begin
			n.target  = tgt;
			n.cnt     = 3'h0;
			n.pending = 1'b0;
		end else if (a.pending) begin
			n.target  = a.buf_code;
			n.pending = 1'b0;
			n.cnt     = 3'h0;
		end
		n.mute = (n.level < `CPA_ATT_MIN);
		return n;
	endfunction

	// ****************************************
	// Control word decode
	// ****************************************
	always_comb begin
		wr_pwr   = wr_valid_i && (wr_word_i.addr == `CPA_ADDR_PWR);
		wr_att_l = wr_valid_i && (wr_word_i.addr == `CPA_ADDR_ATT_L);
		wr_att_r = wr_valid_i && (wr_word_i.addr == `CPA_ADDR_ATT_R);
		wr_clk   = wr_valid_i && (wr_word_i.addr == `CPA_ADDR_CLK_IF);
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_d = st_q;
		if (wr_pwr) begin
			st_d.adc_ps       = wr_word_i.data[`CPA_BIT_ADC_PS];
			st_d.dac_ps       = wr_word_i.data[`CPA_BIT_DAC_PS];
			st_d.single_ended = wr_word_i.data[`CPA_BIT_SE];
		end
		if (wr_clk) begin
			st_d.clk_sel = wr_word_i.data[`CPA_BIT_CSEL];
			st_d.if_mode = wr_word_i.data[`CPA_MS_HI:`CPA_MS_LO];
			st_d.fmt     = wr_word_i.data[`CPA_FMT_HI:`CPA_FMT_LO];
		end
		st_d.adc   = pwr_step(st_q.adc, st_q.adc_ps, fs_tick_i);
		st_d.dac   = pwr_step(st_q.dac, st_q.dac_ps, fs_tick_i);
		st_d.att_l = att_step(st_q.att_l, wr_att_l, wr_word_i.data, fs_tick_i);
		st_d.att_r = att_step(st_q.att_r, wr_att_r, wr_word_i.data, fs_tick_i);
		st_d.busy  = (st_d.att_l.level != st_d.att_l.target) || st_d.att_l.pending
			|| (st_d.att_r.level != st_d.att_r.target) || st_d.att_r.pending;
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q              <= '0;
			st_q.adc_ps       <= `CPA_RST_PS;
			st_q.dac_ps       <= `CPA_RST_PS;
			st_q.single_ended <= `CPA_RST_SE;
			st_q.clk_sel      <= `CPA_RST_CSEL;
			st_q.if_mode      <= `CPA_RST_MS;
			st_q.fmt          <= `CPA_RST_FMT;
			st_q.adc.state    <= CPA_PS_DOWN;
			st_q.adc.down     <= 1'b1;
			st_q.dac.state    <= CPA_PS_DOWN;
			st_q.dac.down     <= 1'b1;
			st_q.att_l.code   <= `CPA_RST_ATT;
			st_q.att_l.target <= `CPA_RST_ATT;
			st_q.att_l.level  <= `CPA_RST_ATT;
			st_q.att_r.code   <= `CPA_RST_ATT;
			st_q.att_r.target <= `CPA_RST_ATT;
			st_q.att_r.level  <= `CPA_RST_ATT;
		end else if (ce_i) begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_comb begin
		adc_power_down_o       = st_q.adc.down;
		adc_fade_level_o       = st_q.adc.fade[10:3];
		dac_power_down_o       = st_q.dac.down;
		dac_fade_level_o       = st_q.dac.fade[10:3];
		dac_single_ended_o     = st_q.single_ended;
		dac_clock_set_select_o = st_q.clk_sel;
		dac_if_mode_o          = st_q.if_mode;
		dac_data_format_o      = st_q.fmt;
		dac_atten_left_o       = st_q.att_l.level;
		dac_atten_right_o      = st_q.att_r.level;
		dac_mute_left_o        = st_q.att_l.mute;
		dac_mute_right_o       = st_q.att_r.mute;
		dac_ramp_busy_o        = st_q.busy;
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	adc_fade_out_a: assert property (
		ce_i && st_q.adc.state == CPA_PS_RUN && st_q.adc_ps |=> st_q.adc.state == CPA_PS_FADE_OUT)
		else $error("adc fade-out not entered");
	adc_down_zero_a: assert property (
		st_q.adc.down |-> st_q.adc.fade == 11'h000 && adc_fade_level_o == 8'h00)
		else $error("adc down with nonzero level");
	adc_resume_a: assert property (
		ce_i && st_q.adc.down && !st_q.adc_ps |=> st_q.adc.state == CPA_PS_FADE_IN)
		else $error("adc resume missing");
	dac_fade_out_a: assert property (
		ce_i && st_q.dac.state == CPA_PS_FADE_OUT && fs_tick_i && st_q.dac_ps && st_q.dac.fade == 11'h000
		|=> dac_power_down_o)
		else $error("dac not powered down after fade");
	dac_resume_a: assert property (
		ce_i && st_q.dac.state == CPA_PS_FADE_IN && fs_tick_i && !st_q.dac_ps
		&& st_q.dac.fade == `CPA_FADE_LAST |=> st_q.dac.state == CPA_PS_RUN && !dac_power_down_o)
		else $error("dac fade-in did not finish");
	ps_indep_a: assert property (
		ce_i && wr_pwr && st_q.dac.state == CPA_PS_RUN && !st_q.dac_ps
		&& !wr_word_i.data[`CPA_BIT_DAC_PS] |=> st_q.dac.state == CPA_PS_RUN)
		else $error("dac disturbed by power write");
	cfg_write_a: assert property (
		ce_i && wr_pwr |=> dac_single_ended_o == $past(wr_word_i.data[`CPA_BIT_SE]))
		else $error("output config not stored");
	if_write_a: assert property (
		ce_i && wr_clk |=> dac_if_mode_o == $past(wr_word_i.data[6:4])
		&& dac_data_format_o == $past(wr_word_i.data[1:0]))
		else $error("interface field not stored");
	att_step_a: assert property (
		ce_i && fs_tick_i && st_q.att_l.cnt == 3'h7 && st_q.att_l.level < st_q.att_l.target
		|=> dac_atten_left_o == $past(st_q.att_l.level) + 8'h01)
		else $error("left ramp step wrong");
	att_hold_a: assert property (
		ce_i && wr_att_r && st_q.att_r.level != st_q.att_r.target
		|=> $stable(st_q.att_r.target) && st_q.att_r.pending)
		else $error("ramp interrupted by new target");
	att_mute_a: assert property (
		st_q.att_r.level < `CPA_ATT_MIN |-> dac_mute_right_o)
		else $error("mute flag missing");
	att_down_a: assert property (
		ce_i && fs_tick_i && st_q.att_r.cnt == 3'h7 && st_q.att_r.level > st_q.att_r.target
		|=> dac_atten_right_o == $past(st_q.att_r.level) - 8'h01)
		else $error("right ramp step wrong");
	att_slow_a: assert property (
		!fs_tick_i && st_q.att_l.level != st_q.att_l.target |=> $stable(dac_atten_left_o))
		else $error("left level moved without tick");
	att_new_a: assert property (
		ce_i && wr_att_l && st_q.att_l.level == st_q.att_l.target
		|=> st_q.att_l.target == (($past(wr_word_i.data) < `CPA_ATT_MIN) ? `CPA_ATT_MUTE
		: $past(wr_word_i.data)) && st_q.att_l.cnt == 3'h0)
		else $error("left target not taken");
	att_buf_run_a: assert property (
		ce_i && st_q.att_r.pending && st_q.att_r.level == st_q.att_r.target && !wr_att_r
		|=> st_q.att_r.target == $past(st_q.att_r.buf_code) && !st_q.att_r.pending)
		else $error("buffered target not run");
	att_last_a: assert property (
		ce_i && wr_att_r && st_q.att_r.level != st_q.att_r.target
		|=> st_q.att_r.buf_code == (($past(wr_word_i.data) < `CPA_ATT_MIN) ? `CPA_ATT_MUTE
		: $past(wr_word_i.data)))
		else $error("buffer not overwritten");
	att_busy_a: assert property (
		ce_i && wr_att_r && st_q.att_r.level != st_q.att_r.target |=> dac_ramp_busy_o)
		else $error("busy low with buffered target");
	mute_left_a: assert property (
		dac_mute_left_o == (dac_atten_left_o < `CPA_ATT_MIN))
		else $error("left mute flag wrong");
	dac_down_zero_a: assert property (
		st_q.dac.down |-> dac_fade_level_o == 8'h00)
		else $error("dac down with nonzero level");
	adc_run_full_a: assert property (
		ce_i && st_q.adc.state == CPA_PS_FADE_IN && fs_tick_i && !st_q.adc_ps
		&& st_q.adc.fade == `CPA_FADE_LAST |=> st_q.adc.state == CPA_PS_RUN && adc_fade_level_o == 8'hFF)
		else $error("adc fade-in did not finish");
	clk_write_a: assert property (
		ce_i && wr_clk |=> dac_clock_set_select_o == $past(wr_word_i.data[`CPA_BIT_CSEL]))
		else $error("clock select not stored");
	dac_stay_down_a: assert property (
		ce_i && st_q.dac.down && st_q.dac_ps |=> dac_power_down_o)
		else $error("dac left power-down");
	adc_stay_down_a: assert property (
		ce_i && st_q.adc.down && st_q.adc_ps |=> adc_power_down_o)
		else $error("adc left power-down");

endmodule

`default_nettype wire

// File: include/cpa_pkg.sv
`default_nettype none

package cpa_pkg;

	typedef enum logic [3:0] {
		CPA_PS_DOWN     = 4'h1,
		CPA_PS_FADE_IN  = 4'h2,
		CPA_PS_RUN      = 4'h4,
		CPA_PS_FADE_OUT = 4'h8
	} cpa_ps_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} cpa_ctrl_word_t;

	typedef struct packed {
		cpa_ps_state_t state;
		logic [10:0]   fade;
		logic          down;
	} cpa_pwr_t;

	typedef struct packed {
		logic [7:0] code;
		logic [7:0] target;
		logic [7:0] level;
		logic [7:0] buf_code;
		logic       pending;
		logic [2:0] cnt;
		logic       mute;
	} cpa_att_t;

	typedef struct packed {
		logic       adc_ps;
		logic       dac_ps;
		logic       single_ended;
		logic       clk_sel;
		logic [2:0] if_mode;
		logic [1:0] fmt;
		logic       busy;
		cpa_pwr_t   adc;
		cpa_pwr_t   dac;
		cpa_att_t   att_l;
		cpa_att_t   att_r;
	} cpa_state_t;

endpackage

`default_nettype wire

// File: include/cpa_regs.svh
`ifndef CPA_REGS_SVH
`define CPA_REGS_SVH

// ****************************************
// Register addresses
// ****************************************
`define CPA_ADDR_PWR        8'h40
`define CPA_ADDR_ATT_L      8'h41
`define CPA_ADDR_ATT_R      8'h42
`define CPA_ADDR_CLK_IF     8'h43

// ****************************************
// Field positions
// ****************************************
`define CPA_BIT_ADC_PS      5
`define CPA_BIT_DAC_PS      4
`define CPA_BIT_SE          0
`define CPA_BIT_CSEL        7
`define CPA_MS_HI           6
`define CPA_MS_LO           4
`define CPA_FMT_HI          1
`define CPA_FMT_LO          0

// ****************************************
// Reset values
// ****************************************
`define CPA_RST_ATT         8'hFF
`define CPA_RST_PS          1'b1
`define CPA_RST_SE          1'b0
`define CPA_RST_CSEL        1'b0
`define CPA_RST_MS          3'h0
`define CPA_RST_FMT         2'h0

// ****************************************
// Attenuation and timing
// ****************************************
`define CPA_ATT_MIN         8'h37
`define CPA_ATT_MUTE        8'h36
`define CPA_ATT_STEP_LAST   3'h7
`define CPA_PS_WAIT_FS      2048
`define CPA_FADE_LAST       11'h7FF

`endif

// File: verification/cpa_codec_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Bench
// ****************************************
module cpa_codec_ctrl_tb;
	import cpa_pkg::*;
	logic           clock, resetn, ce, fs_tick, wr_valid;
	cpa_ctrl_word_t wr_word;
	logic           adc_pd, dac_pd, se, csel, busy, mute_l, mute_r;
	logic [7:0]     adc_fade, dac_fade, att_l, att_r, r;
	logic [2:0]     mode;
	logic [1:0]     fmt;
	int             fails, n_compared;

	cpa_host_model i_cpa_host_model (.clock_i(clock), .fs_tick_o(fs_tick),
		.wr_valid_o(wr_valid), .wr_word_o(wr_word));

	cpa_codec_ctrl i_cpa_codec_ctrl (.clock_i(clock), .resetn_i(resetn), .ce_i(ce),
		.fs_tick_i(fs_tick), .wr_valid_i(wr_valid), .wr_word_i(wr_word),
		.adc_power_down_o(adc_pd), .adc_fade_level_o(adc_fade),
		.dac_power_down_o(dac_pd), .dac_fade_level_o(dac_fade),
		.dac_single_ended_o(se), .dac_clock_set_select_o(csel),
		.dac_if_mode_o(mode), .dac_data_format_o(fmt),
		.dac_atten_left_o(att_l), .dac_atten_right_o(att_r),
		.dac_mute_left_o(mute_l), .dac_mute_right_o(mute_r),
		.dac_ramp_busy_o(busy));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	function automatic logic [7:0] clamp(input logic [7:0] c);
		return (c < 8'h37) ? 8'h36 : c;
	endfunction

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic end_of_test;
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge fs_tick);
		repeat (2) @(negedge clock);
	endtask

	task automatic ramp_done;
		int i;
		i = 0;
		repeat (2) @(negedge clock);
		while (busy !== 1'b0 && i < 9000) begin
			@(negedge clock);
			i++;
		end
		if (i >= 9000) begin
			fails++;
			$display("[ERR] %0t busy %h exp %h", $time, busy, 1'b0);
			end_of_test;
		end
	endtask

	initial begin
		repeat (60000) @(posedge clock);
		fails++;
		end_of_test;
	end

	initial begin
		r      = 8'($urandom(32'hF06E));
		ce     = 1'b1;
		resetn = 1'b0;
		repeat (4) @(negedge clock);
		resetn = 1'b1;
		chk({adc_pd, dac_pd, se, csel, 1'b0, mode}, 8'hC0);
		chk({6'h00, fmt}, 8'h00);
		chk(att_l & att_r, 8'hFF);
		ce = 1'b0;
		i_cpa_host_model.wr(8'h41, 8'h00);
		ce = 1'b1;
		ticks(2);
		chk({busy, att_l[6:0]}, 8'h7F);
		for (int i = 0; i < 7; i++) begin
			r = {1'($urandom), 3'(i), 2'b00, 2'($urandom)};
			i_cpa_host_model.wr(8'h43, r);
			ticks(1);
			chk({csel, mode, 2'b00, fmt}, r);
		end
		i_cpa_host_model.wr(8'h40, 8'h30);
		i_cpa_host_model.wr(8'h41, 8'hFF);
		ticks(2);
		chk({csel, mode, 2'b00, fmt}, r);
		chk({7'h00, busy}, 8'h00);
		i_cpa_host_model.wr(8'h40, 8'h21);
		ticks(1);
		chk({5'h00, adc_pd, dac_pd, se}, 8'h05);
		ticks(2050);
		chk(dac_fade, 8'hFF);
		chk(adc_fade, 8'h00);
		i_cpa_host_model.wr(8'h40, 8'h01);
		ticks(1);
		chk({adc_pd, dac_pd, dac_fade[5:0]}, 8'h3F);
		i_cpa_host_model.wr(8'h40, 8'h10);
		ticks(1);
		chk({6'h00, adc_pd, dac_pd}, 8'h00);
		ticks(2050);
		chk({adc_fade[7:1], se}, 8'hFE);
		chk({dac_pd, dac_fade[6:0]}, 8'h80);
		i_cpa_host_model.wr(8'h40, 8'h30);
		ticks(2050);
		chk({adc_pd, adc_fade[6:0]}, 8'h80);
		i_cpa_host_model.wr(8'h41, 8'hFD);
		ticks(6);
		chk(att_l, 8'hFF);
		ticks(11);
		chk(att_l, 8'hFD);
		i_cpa_host_model.wr(8'h42, 8'h80);
		ticks(3);
		i_cpa_host_model.wr(8'h42, 8'h20);
		r = 8'($urandom);
		i_cpa_host_model.wr(8'h42, r);
		ticks(40);
		chk({7'h00, busy}, 8'h01);
		ramp_done;
		chk(att_r, clamp(r));
		chk({7'h00, mute_r}, {7'h00, r < 8'h37});
		i_cpa_host_model.wr(8'h42, 8'h10);
		ramp_done;
		chk({mute_l, att_r[6:0]}, 8'h36);
		chk({7'h00, mute_r}, 8'h01);
		i_cpa_host_model.wr(8'h41, 8'hFF);
		ramp_done;
		chk(att_l, 8'hFF);
		end_of_test;
	end
endmodule
`default_nettype wire

// File: verification/cpa_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Host controller and timebase
// ****************************************
module cpa_host_model (
	input  wire logic                    clock_i,
	output var  logic                    fs_tick_o,
	output var  logic                    wr_valid_o,
	output var  cpa_pkg::cpa_ctrl_word_t wr_word_o
);
	import cpa_pkg::*;

	initial begin
		fs_tick_o  = 1'b0;
		wr_valid_o = 1'b0;
		wr_word_o  = 16'h0000;
	end

	// One sampling tick every two clocks
	always @(negedge clock_i) begin
		fs_tick_o <= ~fs_tick_o;
	end

	// One control word, then lines scrambled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock_i);
		wr_valid_o <= 1'b1;
		wr_word_o  <= {a, d};
		@(negedge clock_i);
		wr_valid_o <= 1'b0;
		wr_word_o  <= ~{a, d};
	endtask
endmodule
`default_nettype wire
